// >>> hdl/pbec_top.sv
// Pipeline and bus event counting: per-clock increment for selected event
`timescale 1ns/1ps
module pbec_top (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [5:0] event_sel_i,
   input wire logic rd_stall_i,
   input wire logic dtlb_miss_busy_i,
   input wire logic fill_rd_blocked_i,
   input wire logic wr_em_stall_i,
   input wire logic bus_start_i,
   input wire logic bus_done_i,
   input wire logic bus_lock_i,
   input wire logic bus_rmw_write_i,
   input wire logic bus_io_i,
   input wire logic bus_read_i,
   input wire logic bus_cacheable_i,
   input wire logic split_cycle_indicator_i,
   input wire logic backoff_input_n_i,
   input wire logic [1:0] ex_wr_i,
   input wire logic [1:0][2:0] ex_dst_i,
   input wire logic [1:0] ag_valid_i,
   input wire logic [1:0] ag_base_use_i,
   input wire logic [1:0][2:0] ag_base_i,
   input wire logic [1:0] ag_idx_use_i,
   input wire logic [1:0][2:0] ag_idx_i,
   input wire logic fp_valid_i,
   input wire pbec_pkg::pbec_fkind_t fp_kind_i,
   input wire logic [2:0] fp_subops_i,
   input wire logic [4:0] fp_exc_i,
   input wire logic bp_enabled_i,
   input wire logic [3:0] bp_code_u_i,
   input wire logic [3:0] bp_code_v_i,
   input wire logic [3:0] bp_data_i,
   output logic [3:0] inc_amt_o,
   output logic event_hit_o,
   output logic [3:0] breakpoint_match_pins_o
);

   // ----------------------------------------------------------------
   // Leaf decoders
   // ----------------------------------------------------------------
   pbec_evt_if ev_if ();

   pbec_agi u_agi (
      .ex_wr_i(ex_wr_i),
      .ex_dst_i(ex_dst_i),
      .ag_valid_i(ag_valid_i),
      .ag_base_use_i(ag_base_use_i),
      .ag_base_i(ag_base_i),
      .ag_idx_use_i(ag_idx_use_i),
      .ag_idx_i(ag_idx_i),
      .ev(ev_if.agi_src)
   );

   pbec_fpev u_fpev (
      .fp_valid_i(fp_valid_i),
      .fp_kind_i(fp_kind_i),
      .fp_subops_i(fp_subops_i),
      .fp_exc_i(fp_exc_i),
      .ev(ev_if.fp_src)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic backoff_input_s1_r;
   logic backoff_input_s2_r;
   logic wr_stall_d_r;
   pbec_pkg::pbec_bus_st_t bus_st_r;
   pbec_pkg::pbec_bus_st_t bus_st_nxt;
   logic [3:0] inc_amt_r;
   logic [3:0] inc_amt_nxt;
   logic event_hit_r;
   logic [3:0] bp_pins_r;
   logic [3:0] bp_pins_nxt;

   // Back-off arrives from a pin, so two flops before any use
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         backoff_input_s1_r <= 1'b0;
         backoff_input_s2_r <= 1'b0;
      end else begin
         backoff_input_s1_r <= !backoff_input_n_i;
         backoff_input_s2_r <= backoff_input_s1_r;
      end
   end

   // ----------------------------------------------------------------
   // Bus cycle tracker
   // ----------------------------------------------------------------
   // A cycle aborted by back-off returns as a fresh start; the tracker
   // remembers it so the rerun is not seen as new traffic. The sync
   // delay means a back-off in the last two clocks of a cycle is
   // missed; the cycle then already finished and was counted once.
   always_comb begin
      bus_st_nxt = bus_st_r;
      case (bus_st_r)
         pbec_pkg::BUS_IDLE: begin
            if (bus_start_i) begin
               bus_st_nxt = pbec_pkg::BUS_ACTIVE;
            end
         end
         pbec_pkg::BUS_ACTIVE: begin
            if (backoff_input_s2_r) begin
               bus_st_nxt = pbec_pkg::BUS_RESTART;
            end else if (bus_done_i && !bus_start_i) begin
               bus_st_nxt = pbec_pkg::BUS_IDLE;
            end
         end
         pbec_pkg::BUS_RESTART: begin
            if (bus_start_i && !backoff_input_s2_r) begin
               bus_st_nxt = pbec_pkg::BUS_ACTIVE;
            end
         end
         default: begin
            bus_st_nxt = pbec_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         bus_st_r <= pbec_pkg::BUS_IDLE;
      end else begin
         bus_st_r <= bus_st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Event terms
   // ----------------------------------------------------------------
   logic cyc_new;
   logic rd_stall_ev;
   logic wr_stall_ev;
   logic [3:0] lock_amt;
   logic io_ev;
   logic unc_ev;
   logic [3:0] bp_amt_first;
   logic [3:0] bp_amt_second;
   logic sel_ok;

   // A start while restarting is the rerun, not new traffic
   assign cyc_new = bus_start_i &&
                    (bus_st_r != pbec_pkg::BUS_RESTART);

   // Every stalled clock counts, whatever holds the read
   assign rd_stall_ev = rd_stall_i || dtlb_miss_busy_i ||
                        fill_rd_blocked_i;

   // A stall is counted once, at its first clock
   assign wr_stall_ev = wr_em_stall_i && !wr_stall_d_r;

   // Locked reads only; split accesses count twice
   assign lock_amt = (cyc_new && bus_lock_i && !bus_rmw_write_i) ?
      (split_cycle_indicator_i ? 4'h2 : 4'h1) :
      4'h0;

   // Each half of a misaligned access is its own bus start
   assign io_ev = cyc_new && bus_io_i;

   // Uncached memory reads of code, data or page walk
   assign unc_ev = cyc_new && bus_read_i && !bus_cacheable_i &&
                   !bus_io_i;

   // Breakpoint pins: second-pipe code hits only when enabled
   assign bp_pins_nxt = bp_code_u_i | bp_data_i |
      (bp_enabled_i ? bp_code_v_i : 4'h0);

   // Match counts are taken from the same bits that drive the pins
   assign bp_amt_first = {3'h0,
      bp_pins_nxt[pbec_pkg::BP_FIRST_BIT]};
   assign bp_amt_second = {3'h0,
      bp_pins_nxt[pbec_pkg::BP_SECOND_BIT]};

   assign sel_ok = pbec_pkg::evt_valid(event_sel_i);

   // ----------------------------------------------------------------
   // Selection
   // ----------------------------------------------------------------
   // Reserved and unknown codes fall through to zero
   assign inc_amt_nxt = !sel_ok ? 4'h0 :
      (event_sel_i == pbec_pkg::EV_RD_STALL) ? {3'h0, rd_stall_ev} :
      (event_sel_i == pbec_pkg::EV_WR_STALL) ? {3'h0, wr_stall_ev} :
      (event_sel_i == pbec_pkg::EV_LOCKED) ? lock_amt :
      (event_sel_i == pbec_pkg::EV_IO) ? {3'h0, io_ev} :
      (event_sel_i == pbec_pkg::EV_UNC_RD) ? {3'h0, unc_ev} :
      (event_sel_i == pbec_pkg::EV_AGI) ? {2'h0, ev_if.agi_amt} :
      (event_sel_i == pbec_pkg::EV_FLOAT_OPERATION_EVENT) ? ev_if.flop_amt :
      (event_sel_i == pbec_pkg::EV_BP_FIRST) ? bp_amt_first :
      (event_sel_i == pbec_pkg::EV_BP_SECOND) ? bp_amt_second :
      4'h0;

   // Outputs registered so the counter sees one clean amount
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         inc_amt_r <= pbec_pkg::AMT_RST;
         event_hit_r <= 1'b0;
         bp_pins_r <= pbec_pkg::BP_RST;
         wr_stall_d_r <= 1'b0;
      end else begin
         inc_amt_r <= inc_amt_nxt;
         event_hit_r <= (inc_amt_nxt != 4'h0);
         bp_pins_r <= bp_pins_nxt;
         wr_stall_d_r <= wr_em_stall_i;
      end
   end

   assign inc_amt_o = inc_amt_r;
   assign event_hit_o = event_hit_r;
   assign breakpoint_match_pins_o = bp_pins_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_sel(logic [5:0] code);
      event_sel_i == code;
   endsequence

   sequence s_backoff_hit;
      bus_st_r == pbec_pkg::BUS_ACTIVE && backoff_input_s2_r;
   endsequence

   rd_stall_cnt_a: assert property (
      s_sel(pbec_pkg::EV_RD_STALL) and dtlb_miss_busy_i
      |=> inc_amt_o == 4'h1)
      else $error("read stall clock not counted");

   wr_stall_once_a: assert property (
      s_sel(pbec_pkg::EV_WR_STALL) ##0 wr_em_stall_i [*2]
      |=> inc_amt_o == 4'h0)
      else $error("write stall counted more than once");

   lock_write_skip_a: assert property (
      s_sel(pbec_pkg::EV_LOCKED) and bus_rmw_write_i
      |=> inc_amt_o == 4'h0)
      else $error("locked write part counted");

   lock_split_two_a: assert property (
      s_sel(pbec_pkg::EV_LOCKED) and cyc_new and bus_lock_i and
      !bus_rmw_write_i and split_cycle_indicator_i
      |=> inc_amt_o == 4'h2)
      else $error("split locked cycle not counted twice");

   backoff_rerun_a: assert property (
      s_backoff_hit ##1 (s_sel(pbec_pkg::EV_IO) and bus_start_i and
      bus_io_i) |=> inc_amt_o == 4'h0)
      else $error("restarted bus cycle counted again");

   unc_io_skip_a: assert property (
      s_sel(pbec_pkg::EV_UNC_RD) and bus_io_i
      |=> inc_amt_o == 4'h0)
      else $error("I/O read counted as uncached");

   agi_both_a: assert property (
      s_sel(pbec_pkg::EV_AGI) and ag_valid_i == 2'h3 and
      ag_base_use_i == 2'h3 and ex_wr_i[0] and
      ag_base_i[0] == ex_dst_i[0] and ag_base_i[1] == ex_dst_i[0]
      |=> inc_amt_o == 4'h2)
      else $error("double interlock not counted as two");

   fp_supp_a: assert property (
      s_sel(pbec_pkg::EV_FLOAT_OPERATION_EVENT) and fp_exc_i[pbec_pkg::EXC_STACK]
      |=> inc_amt_o == 4'h0)
      else $error("suppressed float operation counted");

   fp_transc_a: assert property (
      s_sel(pbec_pkg::EV_FLOAT_OPERATION_EVENT) and fp_valid_i and fp_exc_i == 5'h0
      and fp_kind_i == pbec_pkg::FK_TRANSC
      |=> inc_amt_o == {1'b0, $past(fp_subops_i)})
      else $error("transcendental step count wrong");

   bp_v_masked_a: assert property (
      !bp_enabled_i && bp_code_u_i == 4'h0 && bp_data_i == 4'h0
      |=> breakpoint_match_pins_o == 4'h0)
      else $error("second-pipe code match seen while disabled");

   bp_pin_match_a: assert property (
      s_sel(pbec_pkg::EV_BP_FIRST)
      |=> inc_amt_o == {3'h0, breakpoint_match_pins_o[0]})
      else $error("breakpoint count differs from pin");

   rd_fill_a: assert property (
      s_sel(pbec_pkg::EV_RD_STALL) and fill_rd_blocked_i
      |=> inc_amt_o == 4'h1)
      else $error("blocked fill read clock not counted");

   lock_read_a: assert property (
      s_sel(pbec_pkg::EV_LOCKED) and cyc_new and bus_lock_i and
      !bus_rmw_write_i and !split_cycle_indicator_i
      |=> inc_amt_o == 4'h1)
      else $error("locked read cycle not counted");

   io_cycle_a: assert property (
      s_sel(pbec_pkg::EV_IO) and cyc_new and bus_io_i
      |=> inc_amt_o == 4'h1)
      else $error("I/O bus cycle not counted");

   unc_read_a: assert property (
      s_sel(pbec_pkg::EV_UNC_RD) and cyc_new and bus_read_i and
      !bus_cacheable_i and !bus_io_i
      |=> inc_amt_o == 4'h1)
      else $error("uncached read not counted");

   agi_one_a: assert property (
      s_sel(pbec_pkg::EV_AGI) and ag_valid_i == 2'h1 and
      ag_base_use_i == 2'h1 and ag_idx_use_i == 2'h0 and
      ex_wr_i == 2'h2 and ag_base_i[0] == ex_dst_i[1]
      |=> inc_amt_o == 4'h1)
      else $error("cross-pipe interlock not counted");

   fp_basic_a: assert property (
      s_sel(pbec_pkg::EV_FLOAT_OPERATION_EVENT) and fp_valid_i and fp_exc_i == 5'h00
      and fp_kind_i == pbec_pkg::FK_MUL
      |=> inc_amt_o == 4'h1)
      else $error("float multiply not counted");

   fp_other_exc_a: assert property (
      s_sel(pbec_pkg::EV_FLOAT_OPERATION_EVENT) and fp_valid_i and fp_exc_i == 5'h10
      and fp_kind_i != pbec_pkg::FK_TRANSC
      |=> inc_amt_o == 4'h1)
      else $error("float op with other exception not counted");

   bp_data_hit_a: assert property (
      s_sel(pbec_pkg::EV_BP_SECOND) and bp_data_i[1]
      |=> inc_amt_o == 4'h1)
      else $error("second register match not counted");

   hit_flag_a: assert property (
      event_hit_o == (inc_amt_o != 4'h0))
      else $error("hit flag disagrees with amount");

   reserved_zero_a: assert property (
      event_sel_i == pbec_pkg::EV_RSV_A ##1
      event_sel_i == pbec_pkg::EV_RSV_B
      |-> inc_amt_o == 4'h0 ##1 inc_amt_o == 4'h0)
      else $error("reserved code produced a count");

endmodule

// >>> hdl/pbec_pkg.sv
// Constants, types and helpers for the pipeline and bus event counter
package pbec_pkg;

   // ----------------------------------------------------------------
   // Event selection codes
   // ----------------------------------------------------------------
   localparam int SEL_W = 6;
   localparam logic [5:0] EV_RD_STALL = 6'h1a;
   localparam logic [5:0] EV_WR_STALL = 6'h1b;
   localparam logic [5:0] EV_LOCKED = 6'h1c;
   localparam logic [5:0] EV_IO = 6'h1d;
   localparam logic [5:0] EV_UNC_RD = 6'h1e;
   localparam logic [5:0] EV_AGI = 6'h1f;
   localparam logic [5:0] EV_RSV_A = 6'h20;
   localparam logic [5:0] EV_RSV_B = 6'h21;
   localparam logic [5:0] EV_FLOAT_OPERATION_EVENT = 6'h22;
   localparam logic [5:0] EV_BP_FIRST = 6'h23;
   localparam logic [5:0] EV_BP_SECOND = 6'h24;

   // ----------------------------------------------------------------
   // Widths, field positions and reset values
   // ----------------------------------------------------------------
   localparam int AMT_W = 4;
   localparam int REG_W = 3;
   localparam int SUBOP_W = 3;
   localparam int BP_W = 4;
   localparam int EXC_W = 5;
   localparam int EXC_DIV_ZERO = 0;
   localparam int EXC_NEG_SQRT = 1;
   localparam int EXC_SPECIAL = 2;
   localparam int EXC_STACK = 3;
   localparam int EXC_OTHER = 4;
   localparam int BP_FIRST_BIT = 0;
   localparam int BP_SECOND_BIT = 1;
   localparam logic [3:0] AMT_RST = 4'h0;
   localparam logic [3:0] BP_RST = 4'h0;

   // Floating-point work kinds reported by the FPU
   typedef enum logic [2:0] {
      FK_ADD, FK_SUB, FK_MUL, FK_DIV, FK_REM, FK_SQRT, FK_TRANSC,
      FK_OTHER
   } pbec_fkind_t;

   // Bus cycle tracker states
   typedef enum logic [1:0] {
      BUS_IDLE, BUS_ACTIVE, BUS_RESTART
   } pbec_bus_st_t;

   // True for a code this block counts
   function automatic logic evt_valid(input logic [5:0] code);
      evt_valid = (code >= EV_RD_STALL) && (code <= EV_BP_SECOND) &&
                  (code != EV_RSV_A) && (code != EV_RSV_B);
   endfunction

endpackage

// >>> hdl/pbec_evt_if.sv
// Interface carrying per-clock event amounts from the leaf decoders
`timescale 1ns/1ps
interface pbec_evt_if;
   logic [1:0] agi_amt;
   logic [3:0] flop_amt;
   modport agi_src (output agi_amt);
   modport fp_src (output flop_amt);
   modport sink (input agi_amt, input flop_amt);
endinterface

// >>> hdl/pbec_agi.sv
// Address-generation interlock detector for both pipes
`timescale 1ns/1ps
module pbec_agi (
   input wire logic [1:0] ex_wr_i,
   input wire logic [1:0][2:0] ex_dst_i,
   input wire logic [1:0] ag_valid_i,
   input wire logic [1:0] ag_base_use_i,
   input wire logic [1:0][2:0] ag_base_i,
   input wire logic [1:0] ag_idx_use_i,
   input wire logic [1:0][2:0] ag_idx_i,
   pbec_evt_if.agi_src ev
);

   // Either execute-stage instruction writes this register
   function automatic logic ex_writes(input logic [1:0] wr,
                                      input logic [1:0][2:0] dst,
                                      input logic [2:0] r);
      ex_writes = (wr[0] && (dst[0] == r)) || (wr[1] && (dst[1] == r));
   endfunction

   logic [1:0] agi_hit;

   // One detector per address-generation pipe
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_pipe
         assign agi_hit[p] = ag_valid_i[p] &&
            ((ag_base_use_i[p] &&
              ex_writes(ex_wr_i, ex_dst_i, ag_base_i[p])) ||
             (ag_idx_use_i[p] &&
              ex_writes(ex_wr_i, ex_dst_i, ag_idx_i[p])));
      end
   endgenerate

   // Both pipes interlocked in one clock give two
   assign ev.agi_amt = {1'b0, agi_hit[0]} + {1'b0, agi_hit[1]};

endmodule

// >>> hdl/pbec_fpev.sv
// Floating-point operation amount decoder
`timescale 1ns/1ps
module pbec_fpev (
   input wire logic fp_valid_i,
   input wire pbec_pkg::pbec_fkind_t fp_kind_i,
   input wire logic [2:0] fp_subops_i,
   input wire logic [4:0] fp_exc_i,
   pbec_evt_if.fp_src ev
);

   logic fp_supp;
   logic [3:0] fp_base;

   // These four exceptions drop the instruction from the count
   assign fp_supp = fp_exc_i[pbec_pkg::EXC_DIV_ZERO] ||
                    fp_exc_i[pbec_pkg::EXC_NEG_SQRT] ||
                    fp_exc_i[pbec_pkg::EXC_SPECIAL] ||
                    fp_exc_i[pbec_pkg::EXC_STACK];

   // Transcendentals report their add/multiply steps; rest count one
   assign fp_base = (fp_kind_i == pbec_pkg::FK_TRANSC) ?
                    {1'b0, fp_subops_i} : 4'h1;

   assign ev.flop_amt = (fp_valid_i && !fp_supp) ? fp_base : 4'h0;

endmodule

// >>> sim/pbec_bus_partner.sv
// Bus unit stand-in: starts bus cycles, ends them, and can back off
`timescale 1ns/1ps
module pbec_bus_partner (
   input wire logic core_clk_i,
   output logic start_o,
   output logic done_o,
   output logic [5:0] attr_o,
   output logic backoff_n_o
);
   // Idle bus: no cycle open, back-off released
   initial begin
      start_o = 1'b0;
      done_o = 1'b0;
      attr_o = 6'h00;
      backoff_n_o = 1'b1;
   end

   // One bus cycle; a backed-off cycle is started a second time
   task automatic bus_cycle(input logic [5:0] at, input int len,
      input bit backoff_input);
      for (int r = 0; r <= int'(backoff_input); r++) begin
         @(posedge core_clk_i);
         start_o <= 1'b1;
         attr_o <= at;
         @(posedge core_clk_i);
         start_o <= 1'b0;
         attr_o <= ~at; // Stale lines flip so nothing leans on them
         if (r == 0 && backoff_input) begin
            backoff_n_o <= 1'b0;
            repeat (3) @(posedge core_clk_i);
            backoff_n_o <= 1'b1;
            repeat (2) @(posedge core_clk_i);
         end
      end
      repeat (len) @(posedge core_clk_i);
      done_o <= 1'b1;
      @(posedge core_clk_i);
      done_o <= 1'b0;
   endtask
endmodule

// >>> sim/pbec_tb_top.sv
// Self-checking bench for the pipeline and bus event counter
`timescale 1ns/1ps
module pbec_tb_top;
   // ------------------------------------------------------------
   // Signals, instances and helpers
   // ------------------------------------------------------------
   logic core_clk_i, rst_n_i;
   logic [5:0] event_sel_i, bus_attr;
   logic rd_stall_i, dtlb_miss_busy_i, fill_rd_blocked_i, wr_em_stall_i;
   logic bus_start_i, bus_done_i, bus_lock_i, bus_rmw_write_i, bus_io_i;
   logic bus_read_i, bus_cacheable_i, split_cycle_indicator_i;
   logic backoff_input_n_i, fp_valid_i, bp_enabled_i, event_hit_o;
   logic [1:0] ex_wr_i, ag_valid_i, ag_base_use_i, ag_idx_use_i;
   logic [1:0][2:0] ex_dst_i, ag_base_i, ag_idx_i;
   pbec_pkg::pbec_fkind_t fp_kind_i;
   logic [2:0] fp_subops_i;
   logic [4:0] fp_exc_i;
   logic [3:0] bp_code_u_i, bp_code_v_i, bp_data_i;
   logic [3:0] inc_amt_o, breakpoint_match_pins_o;
   logic [15:0] sum_r = 16'h0000;
   int bad_count = 0;
   int check_count = 0;

   pbec_top pbec_top_inst (.*);

   pbec_bus_partner pbec_bus_partner_inst (
      .core_clk_i(core_clk_i),
      .start_o(bus_start_i),
      .done_o(bus_done_i),
      .attr_o(bus_attr),
      .backoff_n_o(backoff_input_n_i)
   );

   // Attribute order: lock, rmw write, io, read, cacheable, split
   assign {bus_lock_i, bus_rmw_write_i, bus_io_i, bus_read_i,
      bus_cacheable_i, split_cycle_indicator_i} = bus_attr;

   // Core clock, 40 ns period
   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   // Running total, so bus totals do not hinge on exact latency
   always @(posedge core_clk_i) begin
      sum_r <= sum_r + {12'h000, inc_amt_o};
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // All sources quiet; called at time zero and just after a rising edge
   task automatic idle_in();
      {ex_wr_i, ag_valid_i, ag_base_use_i, ag_idx_use_i} <= 8'h00;
      {ex_dst_i, ag_base_i, ag_idx_i} <= 18'h00000;
      {rd_stall_i, dtlb_miss_busy_i, fill_rd_blocked_i} <= 3'h0;
      {wr_em_stall_i, fp_valid_i, bp_enabled_i} <= 3'h0;
      {bp_code_u_i, bp_code_v_i, bp_data_i} <= 12'h000;
      fp_kind_i <= pbec_pkg::FK_ADD;
      {fp_subops_i, fp_exc_i} <= 8'h00;
   endtask

   // Inputs set at the last edge are answered one clock later
   task automatic step(input logic [3:0] amt, input logic [3:0] pins);
      @(posedge core_clk_i);
      idle_in();
      #1;
      chk_val({12'h000, inc_amt_o}, {12'h000, amt});
      chk_val({15'h0000, event_hit_o}, {15'h0000, amt != 4'h0});
      chk_val({12'h000, breakpoint_match_pins_o}, {12'h000, pins});
      @(posedge core_clk_i);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic sc_reserved();
      logic [5:0] codes [5];
      codes = '{6'h20, 6'h21, 6'h00, 6'h3f, 6'h1d};
      foreach (codes[i]) begin
         @(posedge core_clk_i);
         event_sel_i <= codes[i];
         {rd_stall_i, wr_em_stall_i, fp_valid_i} <= 3'h7;
         bp_code_u_i <= 4'h3;
         step(4'h0, 4'h3);
      end
   endtask

   task automatic sc_stalls();
      @(posedge core_clk_i);
      event_sel_i <= pbec_pkg::EV_RD_STALL;
      rd_stall_i <= 1'b1;
      step(4'h1, 4'h0);
      dtlb_miss_busy_i <= 1'b1;
      step(4'h1, 4'h0);
      {rd_stall_i, fill_rd_blocked_i} <= 2'h3;
      step(4'h1, 4'h0);
      event_sel_i <= pbec_pkg::EV_WR_STALL;
      wr_em_stall_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      chk_val({12'h000, inc_amt_o}, 16'h0001);
      @(posedge core_clk_i);
      step(4'h0, 4'h0);
      wr_em_stall_i <= 1'b1;
      step(4'h1, 4'h0);
   endtask

   // Total counted over whole bus cycles, one or two back to back
   task automatic bus_chk(input logic [5:0] sel, input logic [5:0] at,
      input int n, input bit backoff_input, input logic [15:0] exp);
      logic [15:0] base;
      @(posedge core_clk_i);
      event_sel_i <= sel;
      repeat (2) @(posedge core_clk_i);
      #1;
      base = sum_r;
      repeat (n) pbec_bus_partner_inst.bus_cycle(at, n == 1 ? 6 : 2, backoff_input);
      repeat (3) @(posedge core_clk_i);
      #1;
      chk_val(sum_r - base, exp);
   endtask

   task automatic sc_bus();
      bus_chk(pbec_pkg::EV_LOCKED, 6'h24, 1, 1'b0, 16'h0001);
      bus_chk(pbec_pkg::EV_LOCKED, 6'h30, 1, 1'b0, 16'h0000);
      bus_chk(pbec_pkg::EV_LOCKED, 6'h25, 1, 1'b0, 16'h0002);
      bus_chk(pbec_pkg::EV_LOCKED, 6'h24, 1, 1'b1, 16'h0001);
      bus_chk(pbec_pkg::EV_IO, 6'h08, 2, 1'b0, 16'h0002);
      bus_chk(pbec_pkg::EV_IO, 6'h08, 1, 1'b1, 16'h0001);
      bus_chk(pbec_pkg::EV_UNC_RD, 6'h04, 2, 1'b0, 16'h0002);
      bus_chk(pbec_pkg::EV_UNC_RD, 6'h06, 1, 1'b0, 16'h0000);
      bus_chk(pbec_pkg::EV_UNC_RD, 6'h0c, 1, 1'b0, 16'h0000);
      bus_chk(pbec_pkg::EV_UNC_RD, 6'h04, 1, 1'b1, 16'h0001);
   endtask

   task automatic sc_agi();
      @(posedge core_clk_i);
      event_sel_i <= pbec_pkg::EV_AGI;
      {ex_wr_i, ag_valid_i, ag_base_use_i} <= 6'h15;
      {ex_dst_i, ag_base_i} <= {6'h03, 6'h03};
      step(4'h1, 4'h0);
      {ex_wr_i, ag_valid_i, ag_base_use_i, ag_idx_use_i} <= 8'hb6;
      {ex_dst_i, ag_base_i, ag_idx_i} <= {6'h2d, 6'h05, 6'h28};
      step(4'h2, 4'h0);
      {ex_wr_i, ag_valid_i} <= 4'hf;
      {ex_dst_i, ag_base_i, ag_idx_i} <= {6'h14, 6'h37, 6'h14};
      step(4'h0, 4'h0);
   endtask

   task automatic sc_float_operation_event();
      pbec_pkg::pbec_fkind_t k;
      @(posedge core_clk_i);
      event_sel_i <= pbec_pkg::EV_FLOAT_OPERATION_EVENT;
      for (int i = 0; i < 8; i++) begin
         k = pbec_pkg::pbec_fkind_t'(i);
         {fp_valid_i, fp_subops_i} <= 4'hf;
         fp_kind_i <= k;
         step(k == pbec_pkg::FK_TRANSC ? 4'h7 : 4'h1, 4'h0);
      end
      for (int j = 0; j < 5; j++) begin
         fp_valid_i <= 1'b1;
         fp_exc_i <= 5'h01 << j;
         step(j == pbec_pkg::EXC_OTHER ? 4'h1 : 4'h0, 4'h0);
      end
   endtask

   task automatic bp_case(input logic [12:0] drv, input logic sec,
      input logic [3:0] amt, input logic [3:0] pins);
      @(posedge core_clk_i);
      event_sel_i <= sec ? pbec_pkg::EV_BP_SECOND : pbec_pkg::EV_BP_FIRST;
      {bp_enabled_i, bp_code_u_i, bp_code_v_i, bp_data_i} <= drv;
      step(amt, pins);
   endtask

   // Main sequence: reset held 21 clocks, then every scenario
   initial begin
      rst_n_i = 1'b0;
      event_sel_i = 6'h00;
      idle_in();
      repeat (20) @(posedge core_clk_i);
      #1;
      chk_val({8'h00, inc_amt_o, breakpoint_match_pins_o}, 16'h0000);
      @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      sc_reserved();
      sc_stalls();
      sc_bus();
      sc_agi();
      sc_float_operation_event();
      bp_case(13'h0100, 1'b0, 4'h1, 4'h1);
      bp_case(13'h0010, 1'b0, 4'h0, 4'h0);
      bp_case(13'h1010, 1'b0, 4'h1, 4'h1);
      bp_case(13'h0002, 1'b1, 4'h1, 4'h2);
      bp_case(13'h0002, 1'b0, 4'h0, 4'h2);
      bp_case(13'h10c0, 1'b1, 4'h0, 4'hc);
      close_out();
   end

   // Hang guard: a stuck run is a mismatch
   initial begin
      repeat (20000) @(posedge core_clk_i);
      bad_count++;
      $display("unexpected timeout at %0t: got %h exp %h", $time, 0, 1);
      close_out();
   end
endmodule
